/* rtl/cic_defines.vh */
/*
 * Constants of the configuration and start-up controller: instruction
 * codes, boot address, widths and reset values.
 * Assumes inclusion by bare name from the rtl and verification files.
 */
`ifndef CIC_DEFINES_VH
`define CIC_DEFINES_VH

`define CIC_IR_WIDTH 10
`define CIC_INSTR_LOAD_CHECKSUM 10'h015
`define CIC_INSTR_SET_BOOT_ADDR 10'h016
`define CIC_INSTR_BYPASS 10'h3FF
`define CIC_ADDR_WIDTH 24
`define CIC_BOOT_ADDR_DEFAULT 24'h01_0000
`define CIC_CRC_WIDTH 32
`define CIC_CRC_POLY 32'h04C1_1DB7
`define CIC_CRC_INIT 32'hFFFF_FFFF
`define CIC_WORD_WIDTH 32
`define CIC_INIT_DONE_OPT_BIT 0
`define CIC_FIRST_FRAME_WORDS 4'h1

`endif

/* rtl/cic_buffer.v */
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes a single clock and a synchronous active-low reset.
 */
`default_nettype none
module cic_buffer #(
    parameter WIDTH = 32
) (
    // Clock and reset
    input wire mclk,
    input wire rstn,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // Drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_q [0:1];
    reg wr_q;
    reg rd_q;
    reg [1:0] cnt_q;
    wire push;
    wire pop;

    assign in_ready = (cnt_q != 2'd2);
    assign out_valid = (cnt_q != 2'd0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @(posedge mclk) begin
        if (!rstn) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            cnt_q <= 2'd0;
        end else begin
            if (push) begin
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 2'd1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 2'd1;
            end
        end
    end

    // Storage needs no reset; occupancy guards it
    always @(posedge mclk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule // cic_buffer
`default_nettype wire

/* rtl/cic_config_ctrl.v */
/*
 * Configuration and start-up controller: serial loading, boot address,
 * start-up pins, JTAG instruction register and error-detection checksum.
 * Assumes pins and link clocks are asynchronous to mclk; mclk runs
 * several times faster than cfg_serial_clock and the JTAG clock.
 */
`include "cic_defines.vh"
`default_nettype none
module cic_config_ctrl #(
    parameter INIT_CYCLES = 8,
    parameter CFG_WORDS = 16
) (
    // Clock and reset
    input wire mclk,
    input wire rstn,
    // Configuration pins
    input wire cfg_request_n,
    input wire chip_enable_n,
    input wire cfg_serial_clock,
    input wire cfg_serial_data,
    input wire active_parallel_loading,
    input wire active_serial_loading,
    input wire flash_wait,
    output wire as_clock_out,
    output wire as_clock_oe,
    output wire [`CIC_ADDR_WIDTH-1:0] boot_address,
    output wire ap_bus_oe,
    // Start-up options
    input wire opt_user_clock_en,
    input wire opt_as_clock_from_user,
    input wire opt_oct_gate_en,
    input wire opt_global_oe_en,
    input wire opt_global_clr_en,
    input wire opt_crc_en,
    // Start-up pins
    input wire user_startup_clock,
    input wire termination_cal_complete,
    input wire global_output_enable,
    input wire global_clear_n,
    output wire init_done_out,
    output wire init_done_oe,
    output wire crc_error_out,
    output wire crc_error_oe,
    output wire io_tristate_all,
    output wire user_reg_clear,
    output wire user_mode,
    // Configuration words to the fabric
    output wire word_valid,
    input wire word_ready,
    output wire [`CIC_WORD_WIDTH-1:0] word_data,
    // JTAG
    input wire tck,
    input wire tms_shift_dr,
    input wire tms_shift_ir,
    input wire tms_update,
    input wire tdi,
    output reg tdo_q
);
    localparam ST_RESET = 3'd0;
    localparam ST_LOAD = 3'd1;
    localparam ST_INIT = 3'd2;
    localparam ST_USER = 3'd3;

    function [`CIC_CRC_WIDTH-1:0] crc_step;
        input [`CIC_CRC_WIDTH-1:0] crc;
        input bit_in;
        begin
            if (crc[`CIC_CRC_WIDTH-1] ^ bit_in) begin
                crc_step = {crc[`CIC_CRC_WIDTH-2:0], 1'b0} ^ `CIC_CRC_POLY;
            end else begin
                crc_step = {crc[`CIC_CRC_WIDTH-2:0], 1'b0};
            end
        end
    endfunction

    // Two-stage synchronisers
    reg [1:0] req_s;
    reg [1:0] ce_s;
    reg [1:0] sclk_s;
    reg [1:0] sdat_s;
    reg [1:0] uclk_s;
    reg [1:0] oct_s;
    reg [1:0] goe_s;
    reg [1:0] gclr_s;
    reg [1:0] tck_s;
    reg [1:0] tdi_s;
    reg [1:0] sdr_s;
    reg [1:0] sir_s;
    reg [1:0] upd_s;
    reg sclk_prev_q;
    reg uclk_prev_q;
    reg tck_prev_q;

    always @(posedge mclk) begin
        if (!rstn) begin
            req_s <= 2'b00;
            ce_s <= 2'b11;
            sclk_s <= 2'b00;
            sdat_s <= 2'b00;
            uclk_s <= 2'b00;
            oct_s <= 2'b00;
            goe_s <= 2'b11;
            gclr_s <= 2'b11;
            tck_s <= 2'b00;
            tdi_s <= 2'b00;
            sdr_s <= 2'b00;
            sir_s <= 2'b00;
            upd_s <= 2'b00;
            sclk_prev_q <= 1'b0;
            uclk_prev_q <= 1'b0;
            tck_prev_q <= 1'b0;
        end else begin
            req_s <= {req_s[0], cfg_request_n};
            ce_s <= {ce_s[0], chip_enable_n};
            sclk_s <= {sclk_s[0], cfg_serial_clock};
            sdat_s <= {sdat_s[0], cfg_serial_data};
            uclk_s <= {uclk_s[0], user_startup_clock};
            oct_s <= {oct_s[0], termination_cal_complete};
            goe_s <= {goe_s[0], global_output_enable};
            gclr_s <= {gclr_s[0], global_clear_n};
            tck_s <= {tck_s[0], tck};
            tdi_s <= {tdi_s[0], tdi};
            sdr_s <= {sdr_s[0], tms_shift_dr};
            sir_s <= {sir_s[0], tms_shift_ir};
            upd_s <= {upd_s[0], tms_update};
            sclk_prev_q <= sclk_s[1];
            uclk_prev_q <= uclk_s[1];
            tck_prev_q <= tck_s[1];
        end
    end

    wire sclk_rise = sclk_s[1] && !sclk_prev_q;
    wire uclk_rise = uclk_s[1] && !uclk_prev_q;
    wire tck_rise = tck_s[1] && !tck_prev_q;
    wire in_reset = !req_s[1];

    reg [2:0] state_q;
    reg [4:0] bit_cnt_q;
    reg [`CIC_WORD_WIDTH-1:0] shift_q;
    reg word_push_q;
    reg [`CIC_WORD_WIDTH-1:0] word_q;
    reg [15:0] word_cnt_q;
    reg init_opt_q;
    reg [15:0] init_cnt_q;
    reg [`CIC_CRC_WIDTH-1:0] crc_ref_q;
    reg [`CIC_CRC_WIDTH-1:0] crc_run_q;
    reg crc_err_q;
    reg [`CIC_IR_WIDTH-1:0] ir_shift_q;
    reg [`CIC_IR_WIDTH-1:0] ir_q;
    reg [`CIC_CRC_WIDTH-1:0] dr_shift_q;
    reg [`CIC_ADDR_WIDTH-1:0] boot_q;
    reg ascl_q;
    wire buf_in_ready;

    // Words stall loading until the buffer accepts them
    wire bit_take = sclk_rise && !word_push_q;
    wire init_tick = opt_user_clock_en ? uclk_rise : 1'b1;
    wire oct_ok = !opt_oct_gate_en || oct_s[1];
    // Whole word, including the bit taken on this edge
    wire [`CIC_WORD_WIDTH-1:0] word_next = {shift_q[`CIC_WORD_WIDTH-2:0],
        sdat_s[1]};

    always @(posedge mclk) begin
        if (!rstn || in_reset) begin
            state_q <= ST_RESET;
            bit_cnt_q <= 5'd0;
            shift_q <= {`CIC_WORD_WIDTH{1'b0}};
            word_push_q <= 1'b0;
            word_q <= {`CIC_WORD_WIDTH{1'b0}};
            word_cnt_q <= 16'd0;
            init_opt_q <= 1'b0;
            init_cnt_q <= 16'd0;
            crc_ref_q <= `CIC_CRC_INIT;
        end else begin
            if (word_push_q && buf_in_ready) begin
                word_push_q <= 1'b0;
            end
            case (state_q)
                ST_RESET: begin
                    state_q <= ST_LOAD;
                end
                ST_LOAD: begin
                    if (bit_take) begin
                        shift_q <= word_next;
                        crc_ref_q <= crc_step(crc_ref_q, sdat_s[1]);
                        bit_cnt_q <= bit_cnt_q + 5'd1;
                        if (bit_cnt_q == 5'd31) begin
                            word_q <= word_next;
                            word_push_q <= 1'b1;
                            word_cnt_q <= word_cnt_q + 16'd1;
                            if (word_cnt_q == {12'h000,
                                    `CIC_FIRST_FRAME_WORDS} - 16'd1) begin
                                init_opt_q <= word_next[
                                    `CIC_INIT_DONE_OPT_BIT];
                            end
                            if (word_cnt_q == CFG_WORDS[15:0] - 16'd1) begin
                                state_q <= ST_INIT;
                            end
                        end
                    end
                end
                ST_INIT: begin
                    if (init_tick && init_cnt_q != INIT_CYCLES[15:0]) begin
                        init_cnt_q <= init_cnt_q + 16'd1;
                    end
                    if (init_cnt_q == INIT_CYCLES[15:0] && oct_ok &&
                            !word_push_q) begin
                        state_q <= ST_USER;
                    end
                end
                ST_USER: begin
                    state_q <= ST_USER;
                end
                default: begin
                    state_q <= ST_RESET;
                end
            endcase
        end
    end

    wire is_user = (state_q == ST_USER);
    wire configuring = !is_user;

    cic_buffer #(
        .WIDTH(`CIC_WORD_WIDTH)
    ) u_buf (
        .mclk(mclk),
        .rstn(rstn && !in_reset),
        .in_valid(word_push_q),
        .in_ready(buf_in_ready),
        .in_data(word_q),
        .out_valid(word_valid),
        .out_ready(word_ready),
        .out_data(word_data)
    );

    // Open-drain init-done: oe high pulls the pin low
    assign init_done_out = 1'b0;
    assign init_done_oe = init_opt_q && !is_user && !in_reset;
    assign user_mode = is_user;

    // JTAG over sampled tck; IR ten bits wide
    always @(posedge mclk) begin
        if (!rstn) begin
            ir_shift_q <= {`CIC_IR_WIDTH{1'b0}};
            ir_q <= `CIC_INSTR_BYPASS;
            dr_shift_q <= {`CIC_CRC_WIDTH{1'b0}};
            boot_q <= `CIC_BOOT_ADDR_DEFAULT;
            tdo_q <= 1'b0;
        end else if (tck_rise) begin
            if (sir_s[1]) begin
                ir_shift_q <= {tdi_s[1],
                    ir_shift_q[`CIC_IR_WIDTH-1:1]};
                tdo_q <= ir_shift_q[0];
            end else if (sdr_s[1]) begin
                dr_shift_q <= {tdi_s[1], dr_shift_q[`CIC_CRC_WIDTH-1:1]};
                tdo_q <= dr_shift_q[0];
            end
            if (upd_s[1] && sir_s[1] == 1'b0 && sdr_s[1] == 1'b0) begin
                ir_q <= ir_shift_q;
            end
            if (upd_s[1] && ir_q == `CIC_INSTR_SET_BOOT_ADDR &&
                    configuring) begin
                boot_q <= dr_shift_q[`CIC_ADDR_WIDTH-1:0];
            end
        end
    end

    // Checksum instruction only acts in user mode
    wire edreg_sel = (ir_q == `CIC_INSTR_LOAD_CHECKSUM) && is_user;
    wire edreg_load = tck_rise && upd_s[1] && edreg_sel;

    // JTAG-loaded checksum is compared with the one computed while loading; a mismatch means corruption
    always @(posedge mclk) begin
        if (!rstn || in_reset) begin
            crc_run_q <= `CIC_CRC_INIT;
            crc_err_q <= 1'b0;
        end else if (is_user && opt_crc_en) begin
            if (edreg_load) begin
                crc_run_q <= dr_shift_q;
            end
            crc_err_q <= (crc_run_q != crc_ref_q);
        end
    end

    // Open-drain active high: release lets the pull-up signal the error
    assign crc_error_out = 1'b0;
    assign crc_error_oe = !(crc_err_q && is_user && opt_crc_en);

    assign boot_address = boot_q;
    // Flash wait never enters the loading logic
    assign ap_bus_oe = active_parallel_loading && configuring &&
        !ce_s[1] && !in_reset;
    wire unused_wait = flash_wait;

    // Serial flash clock from user clock or internal divider
    always @(posedge mclk) begin
        if (!rstn) begin
            ascl_q <= 1'b0;
        end else begin
            ascl_q <= ~ascl_q;
        end
    end
    assign as_clock_out = opt_as_clock_from_user ? uclk_s[1] : ascl_q;
    assign as_clock_oe = active_serial_loading && configuring &&
        !ce_s[1] && !in_reset;

    // Options off leave the pins as user I/O, tri-stated until user mode
    assign io_tristate_all = configuring ||
        (opt_global_oe_en && !goe_s[1]);
    assign user_reg_clear = opt_global_clr_en && !gclr_s[1];
endmodule // cic_config_ctrl
`default_nettype wire

/* verification/cic_host_model.sv */
/* Serial configuration host: clocks whole words in, MSB first.
   Assumes the bench calls send_word only between frames. */
`default_nettype none
module cic_host_model (
    // Serial link
    output var logic cfg_serial_clock,
    output var logic cfg_serial_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cfg_serial_clock = 1'b0;
        cfg_serial_data = 1'b0;
    end
    // Clock stands low between frames; stale data is inverted, not held
    task automatic send_word(input logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            cfg_serial_data = w[i];
            #24 cfg_serial_clock = 1'b1;
            #24 cfg_serial_clock = 1'b0;
        end
        cfg_serial_data = ~w[0];
        #150;  // Gap so the word reaches the buffer before the next frame
    endtask
endmodule // cic_host_model
`default_nettype wire

/* verification/cic_config_ctrl_sva.sv */
/* Port checker for the configuration controller.
   Assumes one mclk domain and a synchronous active-low rstn. */
`include "cic_defines.vh"
`default_nettype none
module cic_config_ctrl_sva (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Pins and options
    input wire logic cfg_request_n,
    input wire logic chip_enable_n,
    input wire logic opt_oct_gate_en,
    input wire logic termination_cal_complete,
    input wire logic opt_global_oe_en,
    input wire logic global_output_enable,
    input wire logic opt_global_clr_en,
    input wire logic global_clear_n,
    input wire logic opt_crc_en,
    input wire logic word_ready,
    // Observed outputs
    input wire logic as_clock_oe,
    input wire logic ap_bus_oe,
    input wire logic [`CIC_ADDR_WIDTH-1:0] boot_address,
    input wire logic init_done_oe,
    input wire logic crc_error_oe,
    input wire logic io_tristate_all,
    input wire logic user_reg_clear,
    input wire logic user_mode,
    input wire logic word_valid,
    input wire logic [`CIC_WORD_WIDTH-1:0] word_data
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    // Pins pass two flops, so four cycles of a level are needed
    sequence s_req_held;
        !cfg_request_n [*4];
    endsequence
    sequence s_oct_pending;
        (opt_oct_gate_en && !termination_cal_complete) [*4];
    endsequence
    property p_boot_default;
        $rose(rstn) |-> boot_address == `CIC_BOOT_ADDR_DEFAULT;
    endproperty
    a_boot_default: assert property (p_boot_default)
        else $error("boot address not default after reset");
    property p_req_reset;
        s_req_held |-> !user_mode && !init_done_oe;
    endproperty
    a_req_reset: assert property (p_req_reset)
        else $error("active while configuration request low");
    property p_done_release;
        $rose(user_mode) |-> ##[0:1] !init_done_oe;
    endproperty
    a_done_release: assert property (p_done_release)
        else $error("init done not released at user mode");
    property p_oct_gate;
        s_oct_pending |-> !$rose(user_mode);
    endproperty
    a_oct_gate: assert property (p_oct_gate)
        else $error("user mode before calibration done");
    property p_off_bus;
        chip_enable_n [*4] |-> !ap_bus_oe && !as_clock_oe;
    endproperty
    a_off_bus: assert property (p_off_bus)
        else $error("bus driven while chip enable high");
    property p_global_oe;
        (opt_global_oe_en && !global_output_enable) [*4] |-> io_tristate_all;
    endproperty
    a_global_oe: assert property (p_global_oe)
        else $error("outputs not tri-stated");
    property p_global_clr;
        (opt_global_clr_en && !global_clear_n) [*4] |-> user_reg_clear;
    endproperty
    a_global_clr: assert property (p_global_clr)
        else $error("registers not cleared");
    property p_config_tri;
        !user_mode |-> io_tristate_all;
    endproperty
    a_config_tri: assert property (p_config_tri)
        else $error("user pins driven during configuration");
    property p_word_hold;
        word_valid && !word_ready |=> word_valid && $stable(word_data);
    endproperty
    a_word_hold: assert property (p_word_hold)
        else $error("word dropped or changed while stalled");
    property p_crc_off;
        !opt_crc_en [*2] |-> crc_error_oe;
    endproperty
    a_crc_off: assert property (p_crc_off)
        else $error("error shown with checking disabled");
endmodule // cic_config_ctrl_sva
bind cic_config_ctrl cic_config_ctrl_sva u_cic_config_ctrl_sva (.*);
`default_nettype wire

/* verification/testbench.sv */
/* Self-checking bench of the configuration controller.
   Assumes the rtl folder is on the include path. */
`include "cic_defines.vh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rstn, cfg_request_n, chip_enable_n, flash_wait, word_ready;
    logic active_parallel_loading, active_serial_loading, opt_user_clock_en;
    logic opt_as_clock_from_user, opt_oct_gate_en, opt_global_oe_en;
    logic opt_global_clr_en, opt_crc_en, user_startup_clock, tdi, tck;
    logic termination_cal_complete, global_output_enable, global_clear_n;
    logic tms_shift_dr, tms_shift_ir, tms_update;
    logic cfg_serial_clock, cfg_serial_data;
    wire as_clock_out, as_clock_oe, ap_bus_oe, init_done_out, init_done_oe;
    wire crc_error_out, crc_error_oe, io_tristate_all, user_reg_clear;
    wire user_mode, word_valid, tdo_q;
    wire [`CIC_ADDR_WIDTH-1:0] boot_address;
    wire [`CIC_WORD_WIDTH-1:0] word_data;
    int miscompares = 0;
    int checks_done = 0;
    int n;
    // Rows: oe_en, oe_pin, clr_en, clr_n, expected tristate, expected clear
    logic [5:0] rows [4] = '{6'h26, 6'h39, 6'h0C, 6'h10};
    localparam logic [31:0] W0 = 32'h5A5A_0001;
    localparam logic [31:0] W1 = 32'hC3C3_8001;
    cic_config_ctrl #(.INIT_CYCLES(8), .CFG_WORDS(2)) u_cic_config_ctrl (.*);
    cic_host_model u_cic_host_model (.*);
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Slow tck so every level outlasts the two-flop sampling
    task automatic tck_pulse;
        repeat (4) @(posedge mclk);
        tck <= 1'b1;
        repeat (4) @(posedge mclk);
        tck <= 1'b0;
    endtask
    // Each call toggles the user clock k times, slow enough to be sampled
    task automatic user_clock_edges(input int k);
        repeat (k) begin
            repeat (4) @(posedge mclk);
            user_startup_clock <= !user_startup_clock;
        end
        repeat (6) @(posedge mclk);
        #1;
    endtask
    task automatic jtag_shift(input logic [31:0] v, input int len,
                              input logic ir, input logic [31:0] old);
        for (int i = 0; i < len; i++) begin
            @(posedge mclk);
            tdi <= v[i];
            tms_shift_ir <= ir;
            tms_shift_dr <= !ir;
            tck_pulse();
            check("tdo_q", tdo_q, old[i]);
        end
        @(posedge mclk);
        tms_shift_ir <= 1'b0;
        tms_shift_dr <= 1'b0;
        tms_update <= 1'b1;
        tck_pulse();
        @(posedge mclk);
        tms_update <= 1'b0;
        repeat (4) @(posedge mclk);
        #1;
    endtask
    task automatic pop(input logic [31:0] exp);
        #1;
        for (n = 0; n < 100 && word_valid !== 1'b1; n++) begin
            @(posedge mclk);
            #1;
        end
        check("word_valid", word_valid, 1'b1);
        check("word_data", word_data, exp);
        @(posedge mclk);
        word_ready <= 1'b1;
        @(posedge mclk);
        word_ready <= 1'b0;
    endtask
    function automatic logic [31:0] crc_of(input logic [63:0] bits);
        logic [31:0] c;
        c = `CIC_CRC_INIT;
        for (int i = 63; i >= 0; i--)
            c = {c[30:0], 1'b0} ^ ((c[31] ^ bits[i]) ? `CIC_CRC_POLY : '0);
        return c;
    endfunction
    initial begin
        #200_000;
        miscompares++;
        end_of_test();
    end
    initial begin
        {rstn, cfg_request_n, flash_wait, word_ready, tdi, tck} <= '0;
        {active_parallel_loading, active_serial_loading} <= '0;
        {opt_user_clock_en, opt_as_clock_from_user, opt_oct_gate_en} <= '0;
        {opt_global_oe_en, opt_global_clr_en, opt_crc_en} <= '0;
        {user_startup_clock, termination_cal_complete} <= '0;
        {tms_shift_dr, tms_shift_ir, tms_update} <= '0;
        {chip_enable_n, global_output_enable, global_clear_n} <= '1;
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        check("boot_address", boot_address, `CIC_BOOT_ADDR_DEFAULT);
        check("init_done_oe", init_done_oe, 1'b0);
        check("ap_bus_oe", ap_bus_oe, 1'b0);
        check("init_done_out", init_done_out, 1'b0);
        check("crc_error_out", crc_error_out, 1'b0);
        @(posedge mclk);
        {cfg_request_n, flash_wait, opt_oct_gate_en, opt_crc_en} <= '1;
        chip_enable_n <= 1'b0;
        jtag_shift(`CIC_INSTR_SET_BOOT_ADDR, 10, 1'b1, 32'h0000_0000);
        jtag_shift(32'h00AB_CDE0, 32, 1'b0, 32'h0000_0000);
        check("boot_address", boot_address, 24'hAB_CDE0);
        u_cic_host_model.send_word(W0);
        check("init_done_oe", init_done_oe, 1'b1);
        // Receiver stalls while the second word fills the buffer
        u_cic_host_model.send_word(W1);
        pop(W0);
        pop(W1);
        repeat (40) @(posedge mclk);
        #1;
        check("user_mode", user_mode, 1'b0);
        @(posedge mclk);
        termination_cal_complete <= 1'b1;
        for (n = 0; n < 50 && user_mode !== 1'b1; n++) begin
            @(posedge mclk);
            #1;
        end
        check("user_mode", user_mode, 1'b1);
        check("init_done_oe", init_done_oe, 1'b0);
        foreach (rows[i]) begin
            @(posedge mclk);
            {opt_global_oe_en, global_output_enable} <= rows[i][5:4];
            {opt_global_clr_en, global_clear_n} <= rows[i][3:2];
            repeat (6) @(posedge mclk);
            #1;
            check("io_tristate_all", io_tristate_all, rows[i][1]);
            check("user_reg_clear", user_reg_clear, rows[i][0]);
        end
        check("crc_error_oe", crc_error_oe, 1'b0);
        jtag_shift(`CIC_INSTR_LOAD_CHECKSUM, 10, 1'b1, `CIC_INSTR_SET_BOOT_ADDR);
        jtag_shift(crc_of({W0, W1}), 32, 1'b0, 32'h00AB_CDE0);
        check("crc_error_oe", crc_error_oe, 1'b1);
        @(posedge mclk);
        cfg_request_n <= 1'b0;
        repeat (6) @(posedge mclk);
        #1;
        check("user_mode", user_mode, 1'b0);
        check("init_done_oe", init_done_oe, 1'b0);
        // Second load: user clock paces start-up, calibration not gated
        @(posedge mclk);
        {opt_oct_gate_en, termination_cal_complete} <= 2'b00;
        {opt_user_clock_en, opt_as_clock_from_user} <= 2'b11;
        {active_serial_loading, active_parallel_loading} <= 2'b11;
        cfg_request_n <= 1'b1;
        repeat (6) @(posedge mclk);
        #1;
        check("as_clock_oe", as_clock_oe, 1'b1);
        check("ap_bus_oe", ap_bus_oe, 1'b1);
        @(posedge mclk);
        chip_enable_n <= 1'b1;
        repeat (6) @(posedge mclk);
        #1;
        check("as_clock_oe", as_clock_oe, 1'b0);
        check("ap_bus_oe", ap_bus_oe, 1'b0);
        @(posedge mclk);
        chip_enable_n <= 1'b0;
        user_clock_edges(1);
        check("as_clock_out", as_clock_out, 1'b1);
        user_clock_edges(1);
        check("as_clock_out", as_clock_out, 1'b0);
        u_cic_host_model.send_word(W1);
        u_cic_host_model.send_word(W0);
        pop(W1);
        pop(W0);
        repeat (40) @(posedge mclk);
        #1;
        check("user_mode", user_mode, 1'b0);
        user_clock_edges(14);
        check("user_mode", user_mode, 1'b0);
        user_clock_edges(2);
        check("user_mode", user_mode, 1'b1);
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
